// file: bench/testbench.sv
// self-checking bench for the programmable fir filter
`timescale 1ns/1ps
`default_nettype none
`include "pff_params.svh"
module testbench;
  import pff_pkg::*;
  logic        CLK;
  logic        RSTN;
  logic        WR;
  logic        RD;
  logic        IN_VALID;
  logic        OUT_READY;
  logic        IN_READY;
  logic        OUT_VALID;
  logic [15:0] ADDR;
  logic [15:0] IN_DATA;
  logic [15:0] OUT_DATA;
  logic [7:0]  WDATA;
  logic [7:0]  RDATA;
  logic [3:0]  GPIO;
  logic [15:0] q;
  logic [15:0] resp [0:96];
  int          errors;
  int          check_count;
  // register rows: address, write value, read-back value
  logic [31:0] rg [10] = '{
    {`PFF_A_MODE, 8'hff, 8'h07}, {`PFF_A_GAIN, 8'hff, 8'h77},
    {`PFF_A_XBASE, 8'h34, 8'h34}, {`PFF_A_XLAST, 8'h12, 8'h12},
    {`PFF_A_YBASE, 8'hab, 8'hab}, {`PFF_A_YLAST, 8'hcd, 8'hcd},
    {`PFF_A_DELAY, 8'h5a, 8'h5a}, {`PFF_A_GPIO2, 8'h3c, 8'h3c},
    {16'h0f31, 8'h55, 8'h00}, {`PFF_A_XFER, 8'h02, 8'h00}};
  // impulse rows: mode, output index, expected sample
  logic [26:0] rr [21] = '{
    {PFF_BYPASS, 8'h00, 16'h2000}, {PFF_BYPASS, 8'h01, 16'h0000},
    {3'h3, 8'h00, 16'h2000},
    {PFF_FIR24, 8'h00, 16'h1000}, {PFF_FIR24, 8'h01, 16'h0800},
    {PFF_FIR24, 8'h18, 16'h0000},
    {PFF_FIR48, 8'h00, 16'h1000}, {PFF_FIR48, 8'h18, 16'h1000},
    {PFF_FIR48, 8'h2f, 16'h1000}, {PFF_FIR48, 8'h30, 16'h0000},
    {PFF_CASCADE, 8'h00, 16'h0800}, {PFF_CASCADE, 8'h01, 16'h0400},
    {PFF_CASCADE, 8'h17, 16'h0800}, {PFF_CASCADE, 8'h18, 16'h0400},
    {PFF_FIR96, 8'h01, 16'h0800}, {PFF_FIR96, 8'h2f, 16'h1000},
    {PFF_FIR96, 8'h30, 16'h1000}, {PFF_FIR96, 8'h47, 16'h1000},
    {PFF_FIR96, 8'h5e, 16'h0800}, {PFF_FIR96, 8'h5f, 16'h1000},
    {PFF_FIR96, 8'h60, 16'h0000}};
  logic [2:0]  md [6] = '{PFF_BYPASS, 3'h3, PFF_FIR24, PFF_FIR48, PFF_CASCADE, PFF_FIR96};
  int          nn [6] = '{1, 1, 24, 48, 48, 96};

  pff_filter #(.NPIN(4)) dut (
    .CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .GPIO(GPIO), .IN_VALID(IN_VALID), .IN_DATA(IN_DATA),
    .IN_READY(IN_READY), .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA),
    .OUT_READY(OUT_READY));

  always #20 CLK = ~CLK;

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // inputs change 1 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    ADDR = a;
    WDATA = d;
    WR = 1'b1;
    tick(1);
    WR = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [15:0] a);
    ADDR = a;
    RD = 1'b1;
    tick(1);
    RD = 1'b0;
    q = {8'h00, RDATA};
    tick(1);
  endtask

  task automatic push(input logic [15:0] d);
    IN_DATA = d;
    IN_VALID = 1'b1;
    for (int n = 0; n < 300 && IN_READY !== 1'b1; n++) tick(1);
    tick(1);
    IN_VALID = 1'b0;
  endtask

  task automatic pop();
    OUT_READY = 1'b1;
    for (int n = 0; n < 300 && OUT_VALID !== 1'b1; n++) tick(1);
    q = OUT_DATA;
    tick(1);
    OUT_READY = 1'b0;
  endtask

  task automatic smp(input logic [15:0] d);
    push(d);
    pop();
  endtask

  function automatic logic [15:0] cf(input int n);
    case (n)
      0, 24, 47: cf = 16'h4000;
      1:         cf = 16'h2000;
      default:   cf = 16'h0000;
    endcase
  endfunction

  // mode, gain, settle, then every coefficient byte again
  task automatic setup(input logic [2:0] m, input logic [7:0] g);
    logic [15:0] a;
    logic [15:0] v;
    wr(`PFF_A_MODE, {5'h00, m});
    wr(`PFF_A_GAIN, g);
    tick(125);
    for (int j = 0; j < 48; j++)
    begin
      a = (j < 24) ? `PFF_A_XBASE + 16'(2 * j) : `PFF_A_YBASE + 16'(2 * j - 48);
      v = cf(j);
      wr(a, v[7:0]);
      wr(a + 16'h0001, v[15:8]);
    end
  endtask

  // commit, flush n zeros, then capture the impulse response
  task automatic run(input logic [2:0] m, input logic [7:0] g, input int n);
    setup(m, g);
    wr(`PFF_A_XFER, `PFF_XFER_GO);
    rd(`PFF_A_XFER);
    chk(q, 16'h0000);
    for (int j = 0; j < n; j++) smp(16'h0000);
    smp(16'h2000);
    resp[0] = q;
    for (int j = 1; j <= n; j++)
    begin
      smp(16'h0000);
      resp[j] = q;
    end
  endtask

  // tests need about 1.5 ms
  initial
  begin
    #3200000;
    errors++;
    summarize();
  end

  initial
  begin
    CLK = 1'b0;
    RSTN = 1'b0;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 16'h0000;
    WDATA = 8'h00;
    GPIO = 4'h0;
    IN_VALID = 1'b0;
    IN_DATA = 16'h0000;
    OUT_READY = 1'b0;
    errors = 0;
    check_count = 0;
    tick(16);
    chk({6'h00, IN_READY, OUT_VALID, RDATA}, 16'h0000);
    chk(OUT_DATA, 16'h0000);
    RSTN = 1'b1;
    tick(2);
    chk({15'h0000, IN_READY}, 16'h0001);
    for (int i = 0; i < 10; i++)
    begin
      wr(rg[i][31:16], rg[i][15:8]);
      if (i == 1) tick(125);
      rd(rg[i][31:16]);
      chk(q, {8'h00, rg[i][7:0]});
    end
    // shadow only, then commit from pin 2
    setup(PFF_FIR24, 8'h00);
    smp(16'h2000);
    chk(q, 16'h0000);
    wr(`PFF_A_GPIO0, 8'h82);
    GPIO[2] = 1'b1;
    tick(8);
    GPIO[2] = 1'b0;
    rd(`PFF_A_XFER);
    chk(q, 16'h0000);
    smp(16'h2000);
    chk(q, 16'h1800);
    wr(`PFF_A_GPIO0, 8'h00);
    for (int k = 0; k < 6; k++)
    begin
      run(md[k], 8'h00, nn[k]);
      for (int i = 0; i < 21; i++)
        if (rr[i][26:24] === md[k])
          chk(resp[rr[i][23:16]], rr[i][15:0]);
    end
    // x gain +6 dB, y gain -12 dB
    run(PFF_FIR48, 8'h61, 24);
    chk(resp[0], 16'h2000);
    chk(resp[24], 16'h0400);
    // x gain -6 dB, y gain +12 dB
    run(PFF_FIR48, 8'h27, 24);
    chk(resp[0], 16'h0800);
    chk(resp[24], 16'h4000);
    // fill the output buffer with the sink stalled
    wr(`PFF_A_MODE, 8'h00);
    push(16'h1111);
    tick(1);
    push(16'h2222);
    tick(4);
    chk({15'h0000, IN_READY}, 16'h0001);
    chk({15'h0000, OUT_VALID}, 16'h0001);
    chk(OUT_DATA, 16'h1111);
    pop();
    chk(q, 16'h1111);
    tick(1);
    pop();
    chk(q, 16'h2222);
    tick(2);
    chk({15'h0000, IN_READY}, 16'h0001);
    // reset in mid-run clears registers and stream
    wr(`PFF_A_MODE, 8'h02);
    push(16'h1234);
    tick(3);
    RSTN = 1'b0;
    tick(2);
    chk({6'h00, IN_READY, OUT_VALID, RDATA}, 16'h0000);
    RSTN = 1'b1;
    tick(2);
    chk({15'h0000, IN_READY}, 16'h0001);
    rd(`PFF_A_MODE);
    chk(q, 16'h0000);
    summarize();
  end
endmodule // testbench
`default_nettype wire

// file: verilog/pff_filter.sv
// programmable fir filter with shadow coefficients and output buffer
`timescale 1ns/1ps
`default_nettype none
`include "pff_params.svh"
module pff_filter
  import pff_pkg::*;
#(
  parameter int NPIN = 4
)(
  input  wire logic            CLK,
  input  wire logic            RSTN,
  input  wire logic [15:0]     ADDR,
  input  wire logic [7:0]      WDATA,
  input  wire logic            WR,
  input  wire logic            RD,
  output logic      [7:0]      RDATA,
  input  wire logic [NPIN-1:0] GPIO,
  input  wire logic            IN_VALID,
  input  wire logic [15:0]     IN_DATA,
  output logic                 IN_READY,
  output logic                 OUT_VALID,
  output logic      [15:0]     OUT_DATA,
  input  wire logic            OUT_READY
);
  localparam int NT = `PFF_BANK_TAPS;

  function automatic logic signed [39:0] gain_f(input logic signed [31:0] p,
                                                input logic [2:0] g);
    logic signed [39:0] e;
    e = 40'(p);
    unique case (g)
      3'h6:    gain_f = e >>> 2;
      3'h7:    gain_f = e >>> 1;
      3'h1:    gain_f = e <<< 1;
      3'h2:    gain_f = e <<< 2;
      default: gain_f = e;
    endcase
  endfunction

  function automatic logic [15:0] sat_f(input logic signed [39:0] a);
    logic signed [39:0] s;
    s = a >>> `PFF_FRAC;
    if (s > 40'sh7fff)
      sat_f = 16'h7fff;
    else if (s < -40'sh8000)
      sat_f = 16'h8000;
    else
      sat_f = s[15:0];
  endfunction

  // registers
  logic [7:0]  mode_r, mode_nxt, gain_r, gain_nxt, dly_r, dly_nxt;
  logic [7:0]  gcfg_r [3];
  logic [7:0]  gcfg_nxt [3];
  logic [15:0] shx_r [NT];
  logic [15:0] shx_nxt [NT];
  logic [15:0] shy_r [NT];
  logic [15:0] shy_nxt [NT];
  logic [15:0] acx_r [NT];
  logic [15:0] acx_nxt [NT];
  logic [15:0] acy_r [NT];
  logic [15:0] acy_nxt [NT];
  logic        xfer_r, xfer_nxt;
  logic [7:0]  rdata_nxt;
  logic [NPIN-1:0] gs1_r, gs2_r, gs3_r;
  logic        pin_rise;
  logic [15:0] off;
  pff_state_t  state_r, state_nxt;

  always_comb
  begin
    mode_nxt = mode_r;
    gain_nxt = gain_r;
    dly_nxt  = dly_r;
    gcfg_nxt = gcfg_r;
    shx_nxt  = shx_r;
    shy_nxt  = shy_r;
    xfer_nxt = xfer_r;
    rdata_nxt = 8'h00;
    off = 16'h0000;
    pin_rise = gcfg_r[0][`PFF_GPIO_EN] && gs2_r[gcfg_r[0][1:0]] && !gs3_r[gcfg_r[0][1:0]]; // R15
    if (state_r == PFF_S_IDLE)
      xfer_nxt = 1'b0; // R22
    if (WR)
    begin
      if (ADDR == `PFF_A_MODE)
        mode_nxt = {5'h00, WDATA[2:0]}; // R1 R8
      else if (ADDR == `PFF_A_GAIN)
        gain_nxt = WDATA & 8'h77; // R18
      else if (ADDR == `PFF_A_DELAY)
        dly_nxt = WDATA; // R12
      else if (ADDR >= `PFF_A_GPIO0 && ADDR <= `PFF_A_GPIO2)
        gcfg_nxt[ADDR[1:0]] = WDATA; // R15
      else if (ADDR >= `PFF_A_XBASE && ADDR <= `PFF_A_XLAST)
      begin
        off = ADDR - `PFF_A_XBASE;
        if (off[0]) shx_nxt[off[5:1]][15:8] = WDATA; // R10 R20
        else        shx_nxt[off[5:1]][7:0]  = WDATA; // R20
      end
      else if (ADDR >= `PFF_A_YBASE && ADDR <= `PFF_A_YLAST)
      begin
        off = ADDR - `PFF_A_YBASE;
        if (off[0]) shy_nxt[off[5:1]][15:8] = WDATA; // R11 R20
        else        shy_nxt[off[5:1]][7:0]  = WDATA; // R20
      end
    end
    if ((WR && ADDR == `PFF_A_XFER && WDATA == `PFF_XFER_GO) || pin_rise)
      xfer_nxt = 1'b1; // R14 R16
    if (RD)
    begin
      if (ADDR == `PFF_A_MODE) rdata_nxt = mode_r;
      else if (ADDR == `PFF_A_GAIN) rdata_nxt = gain_r;
      else if (ADDR == `PFF_A_DELAY) rdata_nxt = dly_r;
      else if (ADDR == `PFF_A_XFER) rdata_nxt = {7'h00, xfer_r}; // R22
      else if (ADDR >= `PFF_A_GPIO0 && ADDR <= `PFF_A_GPIO2) rdata_nxt = gcfg_r[ADDR[1:0]];
      else if (ADDR >= `PFF_A_XBASE && ADDR <= `PFF_A_XLAST)
      begin
        off = ADDR - `PFF_A_XBASE;
        rdata_nxt = off[0] ? shx_r[off[5:1]][15:8] : shx_r[off[5:1]][7:0];
      end
      else if (ADDR >= `PFF_A_YBASE && ADDR <= `PFF_A_YLAST)
      begin
        off = ADDR - `PFF_A_YBASE;
        rdata_nxt = off[0] ? shy_r[off[5:1]][15:8] : shy_r[off[5:1]][7:0];
      end
    end
    // copy only between samples
    acx_nxt = acx_r;
    acy_nxt = acy_r;
    if (state_r == PFF_S_IDLE && xfer_r)
    begin
      acx_nxt = shx_r; // R13 R22
      acy_nxt = shy_r; // R13
    end
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      mode_r <= 8'h00;
      gain_r <= 8'h00;
      dly_r  <= 8'h00;
      xfer_r <= 1'b0;
      RDATA  <= 8'h00;
      gs1_r  <= '0;
      gs2_r  <= '0;
      gs3_r  <= '0;
      for (int i = 0; i < 3; i++) gcfg_r[i] <= 8'h00;
      for (int i = 0; i < NT; i++)
      begin
        shx_r[i] <= 16'h0000;
        shy_r[i] <= 16'h0000;
        acx_r[i] <= 16'h0000;
        acy_r[i] <= 16'h0000;
      end
    end
    else
    begin
      mode_r <= mode_nxt;
      gain_r <= gain_nxt;
      dly_r  <= dly_nxt;
      xfer_r <= xfer_nxt;
      RDATA  <= rdata_nxt;
      gs1_r  <= GPIO;
      gs2_r  <= gs1_r;
      gs3_r  <= gs2_r;
      gcfg_r <= gcfg_nxt;
      shx_r  <= shx_nxt;
      shy_r  <= shy_nxt;
      acx_r  <= acx_nxt;
      acy_r  <= acy_nxt;
    end
  end

  // sample engine
  logic [2:0]  run_r, run_nxt;
  logic [6:0]  idx_r, idx_nxt, last;
  logic signed [39:0] acc_r, acc_nxt;
  logic [15:0] dl1_r [`PFF_N96];
  logic [15:0] dl1_nxt [`PFF_N96];
  logic [15:0] dl2_r [NT];
  logic [15:0] dl2_nxt [NT];
  logic [15:0] res_r, res_nxt, o_nxt, sp_nxt;
  logic        rdy_nxt, ov_nxt, spv_r, spv_nxt, accept, pop;
  logic [15:0] sp_r;
  logic [6:0]  j;
  logic [15:0] c, s;
  logic [2:0]  g;

  always_comb
  begin
    state_nxt = state_r;
    run_nxt = run_r;
    idx_nxt = idx_r;
    acc_nxt = acc_r;
    dl1_nxt = dl1_r;
    dl2_nxt = dl2_r;
    res_nxt = res_r;
    j = idx_r;
    c = 16'h0000;
    s = dl1_r[idx_r];
    g = gain_r[`PFF_GAIN_X_LO +: 3];
    unique case (run_r)
      PFF_FIR48:   last = 7'(`PFF_N48 - 1); // R3
      PFF_FIR96:   last = 7'(`PFF_N96 - 1); // R5
      default:     last = 7'(NT - 1); // R2 R4
    endcase
    accept = IN_READY && IN_VALID;
    pop = OUT_VALID && OUT_READY;
    ov_nxt = OUT_VALID && !pop;
    o_nxt = OUT_DATA;
    spv_nxt = spv_r;
    sp_nxt = sp_r;
    if (pop && spv_r)
    begin
      ov_nxt = 1'b1;
      o_nxt = sp_r;
      spv_nxt = 1'b0;
    end
    unique case (state_r)
      PFF_S_IDLE:
        if (accept)
        begin
          for (int i = `PFF_N96 - 1; i > 0; i--) dl1_nxt[i] = dl1_r[i-1];
          dl1_nxt[0] = IN_DATA;
          run_nxt = mode_r[2:0];
          acc_nxt = '0;
          idx_nxt = 7'h00;
          res_nxt = IN_DATA;
          if (mode_r[2:0] == PFF_FIR24 || mode_r[2:0] == PFF_FIR48 ||
              mode_r[2:0] == PFF_CASCADE || mode_r[2:0] == PFF_FIR96)
            state_nxt = PFF_S_MAC1;
          else
            state_nxt = PFF_S_OUT; // R1
        end
      PFF_S_MAC1:
      begin
        if (idx_r >= 7'(`PFF_N48))
          j = 7'(`PFF_N96 - 1) - idx_r; // R5
        if (j < 7'(NT))
          c = acx_r[j[4:0]]; // R2
        else
        begin
          c = acy_r[5'(j - 7'(NT))]; // R3 R21
          g = gain_r[`PFF_GAIN_Y_LO +: 3];
        end
        acc_nxt = acc_r + gain_f(32'($signed(s)) * 32'($signed(c)), g); // R19
        idx_nxt = idx_r + 7'h01;
        if (idx_r == last)
        begin
          idx_nxt = 7'h00;
          if (run_r == PFF_CASCADE)
          begin
            for (int i = NT - 1; i > 0; i--) dl2_nxt[i] = dl2_r[i-1];
            dl2_nxt[0] = sat_f(acc_nxt); // R4
            acc_nxt = '0;
            state_nxt = PFF_S_MAC2;
          end
          else
          begin
            res_nxt = sat_f(acc_nxt);
            state_nxt = PFF_S_OUT;
          end
        end
      end
      PFF_S_MAC2:
      begin
        acc_nxt = acc_r + gain_f(32'($signed(dl2_r[idx_r[4:0]])) *
                                 32'($signed(acy_r[idx_r[4:0]])),
                                 gain_r[`PFF_GAIN_Y_LO +: 3]); // R4
        idx_nxt = idx_r + 7'h01;
        if (idx_r == 7'(NT - 1))
        begin
          res_nxt = sat_f(acc_nxt);
          state_nxt = PFF_S_OUT;
        end
      end
      PFF_S_OUT:
        if (!spv_nxt)
        begin
          if (!ov_nxt)
          begin
            ov_nxt = 1'b1;
            o_nxt = res_r;
          end
          else
          begin
            spv_nxt = 1'b1;
            sp_nxt = res_r;
          end
          state_nxt = PFF_S_IDLE;
        end
    endcase
    rdy_nxt = (state_nxt == PFF_S_IDLE);
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_r   <= PFF_S_IDLE;
      run_r     <= 3'h0;
      idx_r     <= 7'h00;
      acc_r     <= '0;
      res_r     <= 16'h0000;
      IN_READY  <= 1'b0;
      OUT_VALID <= 1'b0;
      OUT_DATA  <= 16'h0000;
      spv_r     <= 1'b0;
      sp_r      <= 16'h0000;
      for (int i = 0; i < `PFF_N96; i++) dl1_r[i] <= 16'h0000;
      for (int i = 0; i < NT; i++) dl2_r[i] <= 16'h0000;
    end
    else
    begin
      state_r   <= state_nxt;
      run_r     <= run_nxt;
      idx_r     <= idx_nxt;
      acc_r     <= acc_nxt;
      res_r     <= res_nxt;
      IN_READY  <= rdy_nxt;
      OUT_VALID <= ov_nxt;
      OUT_DATA  <= o_nxt;
      spv_r     <= spv_nxt;
      sp_r      <= sp_nxt;
      dl1_r     <= dl1_nxt;
      dl2_r     <= dl2_nxt;
    end
  end

  // checks
  property p_bypass;
    @(posedge CLK) disable iff (!RSTN)
      accept && mode_r[2:0] == PFF_BYPASS |=> state_r == PFF_S_OUT && res_r == $past(IN_DATA);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass did not pass sample"); // R1
  property p_fir24;
    @(posedge CLK) disable iff (!RSTN)
      accept && mode_r[2:0] == PFF_FIR24 |-> ##25 state_r == PFF_S_OUT;
  endproperty
  a_fir24: assert property (p_fir24) else $error("24-tap length wrong"); // R2
  property p_fir48;
    @(posedge CLK) disable iff (!RSTN)
      accept && mode_r[2:0] == PFF_FIR48 |-> ##48 state_r == PFF_S_MAC1 ##1 state_r == PFF_S_OUT;
  endproperty
  a_fir48: assert property (p_fir48) else $error("48-tap length wrong"); // R3
  property p_casc;
    @(posedge CLK) disable iff (!RSTN)
      accept && mode_r[2:0] == PFF_CASCADE |-> ##25 state_r == PFF_S_MAC2 ##24 state_r == PFF_S_OUT;
  endproperty
  a_casc: assert property (p_casc) else $error("cascade sequence wrong"); // R4
  property p_fir96;
    @(posedge CLK) disable iff (!RSTN)
      accept && mode_r[2:0] == PFF_FIR96 |-> ##97 state_r == PFF_S_OUT;
  endproperty
  a_fir96: assert property (p_fir96) else $error("96-tap length wrong"); // R5
  property p_xfer;
    @(posedge CLK) disable iff (!RSTN)
      WR && ADDR == `PFF_A_XFER && WDATA == `PFF_XFER_GO |=> xfer_r ##[0:200] !xfer_r;
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer not taken or not cleared"); // R14
  property p_atomic;
    @(posedge CLK) disable iff (!RSTN)
      state_r != PFF_S_IDLE |=> acx_r[0] == $past(acx_r[0]) && acy_r[0] == $past(acy_r[0]);
  endproperty
  a_atomic: assert property (p_atomic) else $error("coefficients changed mid sample"); // R22
  property p_pin;
    @(posedge CLK) disable iff (!RSTN)
      pin_rise |=> xfer_r;
  endproperty
  a_pin: assert property (p_pin) else $error("pin edge lost"); // R16
  property p_byte;
    @(posedge CLK) disable iff (!RSTN)
      WR && ADDR == (`PFF_A_XBASE + 16'h0001) |=> shx_r[0][15:8] == $past(WDATA);
  endproperty
  a_byte: assert property (p_byte) else $error("odd byte not high half"); // R20
  c_casc: cover property (@(posedge CLK) state_r == PFF_S_MAC2 ##1 state_r == PFF_S_MAC2);
  c_full: cover property (@(posedge CLK) spv_r && !OUT_READY);
  c_pin:  cover property (@(posedge CLK) pin_rise);
endmodule // pff_filter
`default_nettype wire

// file: verilog/pff_params.svh
// constants and offsets for the programmable fir filter
//
// Contract
// R1: three-bit mode field; 000 bypasses, 001/010/100/111 valid, others unused.
// R2: mode 001 runs one 24-tap filter using the first bank only.
// R3: mode 010 joins both banks into one 48-tap filter.
// R4: mode 100 runs first-bank 24-tap then second-bank 24-tap in series.
// R5: mode 111 joins both banks into one 96-tap filter.
// R6: controller starts the sample clock before any configuration.
// R7: controller writes mode and gains before loading coefficients.
// R8: only the primary path filter exists; no quadrature mode.
// R9: controller waits at least 5 us after mode set before coefficient writes.
// R10: first-bank coefficients enter shadow storage at bytes 0x0e00..0x0e2f.
// R11: second-bank coefficients enter shadow storage at bytes 0x0f00..0x0f2f.
// R12: optional tapped-delay byte at 0x0f30 may be written or left alone.
// R13: shadow coefficients act only after a transfer copies them all.
// R14: writing 0x01 to 0x000f triggers a coefficient transfer.
// R15: one general-purpose pin may be chosen as transfer input via 0x0040..0x0042.
// R16: a rising edge on the chosen pin starts a transfer.
// R17: controller rewrites all coefficients after any mode change; the bench skips this in its buffer and reset tests.
// R18: three-bit gains, 110 -12, 111 -6, 000 0, 001 +6, 010 +12 dB.
// R19: coefficients are signed 16-bit, one sign and fifteen fraction bits.
// R20: each coefficient takes an even byte (low) and next odd byte (high).
// R21: second bank unused in 24-tap mode; taps 24..47 or cascade stage else.
// R22: transfer applies between samples only; transfer bit reads cleared after.
`ifndef PFF_PARAMS_SVH
`define PFF_PARAMS_SVH
`define PFF_A_XFER     16'h000f
`define PFF_A_GPIO0    16'h0040
`define PFF_A_GPIO2    16'h0042
`define PFF_A_MODE     16'h0df8
`define PFF_A_GAIN     16'h0df9
`define PFF_A_XBASE    16'h0e00
`define PFF_A_XLAST    16'h0e2f
`define PFF_A_YBASE    16'h0f00
`define PFF_A_YLAST    16'h0f2f
`define PFF_A_DELAY    16'h0f30
`define PFF_XFER_GO    8'h01
`define PFF_GAIN_X_LO  0
`define PFF_GAIN_Y_LO  4
`define PFF_GPIO_EN    7
`define PFF_FRAC       15
`define PFF_BANK_TAPS  24
`define PFF_N48        48
`define PFF_N96        96
`endif

// file: verilog/pff_pkg.sv
// types for the programmable fir filter
package pff_pkg;
  typedef enum logic [2:0] {
    PFF_BYPASS  = 3'b000,
    PFF_FIR24   = 3'b001,
    PFF_FIR48   = 3'b010,
    PFF_CASCADE = 3'b100,
    PFF_FIR96   = 3'b111
  } pff_mode_t;
  typedef enum logic [1:0] {
    PFF_S_IDLE = 2'b00,
    PFF_S_MAC1 = 2'b01,
    PFF_S_MAC2 = 2'b10,
    PFF_S_OUT  = 2'b11
  } pff_state_t;
endpackage
